// *** verilog/dual_recloser_sequencer.sv ***
// Master and slave automatic reclose sequencer for two breakers with APB registers.
// Assumes trip and breaker inputs synchronous to clk_sys; APB with no wait states.
`timescale 1ns/1ns
module dual_recloser_sequencer
    import reclose_pkg::*;
#(
    parameter int RCL_1PH_T  = RCL_1PH_CYC,
    parameter int RCL_3PH1_T = RCL_3PH1_CYC,
    parameter int RCL_3PHN_T = RCL_3PHN_CYC,
    parameter int SEC1_T     = SEC1_CYC,
    parameter int SEC2_T     = SEC2_CYC,
    parameter int MAN_SEC_T  = MAN_SEC_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_r,
    output logic             pready_r,
    output logic             pslverr_r,
    input  wire logic        external_trip_activation,
    input  wire logic        three_phase_trip_activation,
    input  wire logic        breaker1_closed,
    input  wire logic        breaker2_closed,
    input  wire logic        counter_reset_in,
    output logic             seq_master_r,
    output logic             seq_slave_r,
    output logic             slave_wait_r,
    output logic             sec_time2_r,
    output logic             lockout_r,
    output logic             lockout_definite_r,
    output logic             reclose_master_r,
    output logic             reclose_slave_r,
    output logic             irq_r
);
    state_t             state_r;
    logic [1:0]         mode_r;
    logic               enable_r;
    logic               cnt_clear_r;
    logic               trip_d_r;
    logic               trip_evt;
    logic               trip_3ph;
    logic               first_3ph_r;
    logic               shot_3ph_r;
    logic               slave_active_r;
    logic [2:0]         attempt_r;
    logic [2:0]         max_shots;
    logic               both_closed;
    logic               tmr_start;
    logic [31:0]        tmr_load;
    logic               tmr_done;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_en_r;
    logic [IRQ_W-1:0]   irq_evt;
    logic [IRQ_W-1:0]   irq_clr;
    logic               lockout_d_r;
    logic               slave_active_d_r;
    logic               wr_en;
    logic               setup;
    logic [CNT_W-1:0]   m_1ph;
    logic [CNT_W-1:0]   m_3ph;
    logic [CNT_W-1:0]   s_1ph;
    logic [CNT_W-1:0]   s_3ph;

    // ****************************************
    // Trip decode
    // ****************************************
    assign trip_evt    = external_trip_activation && !trip_d_r;
    assign trip_3ph    = three_phase_trip_activation || (mode_r == MODE_3P);
    assign both_closed = breaker1_closed && breaker2_closed;
    assign max_shots   = (mode_r == MODE_DEP && first_3ph_r) ? 3'h1 : 3'(MAX_SHOTS);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trip_d_r <= 1'b0;
        end else begin
            trip_d_r <= external_trip_activation;
        end
    end

    // ****************************************
    // Timer control
    // ****************************************
    always_comb begin
        tmr_start = 1'b0;
        tmr_load  = 32'h0000_0001;
        case (state_r)
            ST_IDLE: begin
                if (trip_evt && enable_r) begin
                    tmr_start = 1'b1;
                    tmr_load  = trip_3ph ? 32'(RCL_3PH1_T) : 32'(RCL_1PH_T);
                end
            end
            ST_DEAD: begin
                if (tmr_done) begin
                    tmr_start = 1'b1;
                    tmr_load  = sec_time2_r ? 32'(SEC2_T) : 32'(SEC1_T);
                end
            end
            ST_SECURE: begin
                if (trip_evt && attempt_r < max_shots) begin
                    tmr_start = 1'b1;
                    tmr_load  = 32'(RCL_3PHN_T);
                end
            end
            ST_LOCK: begin
                if (both_closed) begin
                    tmr_start = 1'b1;
                    tmr_load  = 32'(MAN_SEC_T);
                end
            end
            default: begin
                tmr_start = 1'b0;
            end
        endcase
    end

    interval_timer #(
        .W (32)
    ) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .start   (tmr_start),
        .load    (tmr_load),
        .done    (tmr_done)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r            <= ST_IDLE;
            seq_master_r       <= 1'b0;
            seq_slave_r        <= 1'b0;
            slave_wait_r       <= 1'b0;
            sec_time2_r        <= 1'b0;
            lockout_r          <= 1'b0;
            lockout_definite_r <= 1'b0;
            reclose_master_r   <= 1'b0;
            reclose_slave_r    <= 1'b0;
            first_3ph_r        <= 1'b0;
            shot_3ph_r         <= 1'b0;
            slave_active_r     <= 1'b0;
            attempt_r          <= 3'h0;
        end else begin
            reclose_master_r <= 1'b0;
            reclose_slave_r  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (trip_evt && enable_r) begin
                        state_r        <= ST_DEAD;
                        seq_master_r   <= 1'b1;
                        seq_slave_r    <= 1'b1;
                        slave_wait_r   <= 1'b1;
                        sec_time2_r    <= 1'b0;
                        slave_active_r <= 1'b0;
                        attempt_r      <= 3'h1;
                        first_3ph_r    <= trip_3ph;
                        shot_3ph_r     <= trip_3ph;
                    end
                end
                ST_DEAD: begin
                    if (tmr_done) begin
                        state_r <= ST_SECURE;
                        if (slave_active_r) begin
                            reclose_slave_r <= 1'b1;
                        end else begin
                            reclose_master_r <= 1'b1;
                        end
                    end
                end
                ST_SECURE: begin
                    if (trip_evt) begin
                        if (attempt_r >= max_shots) begin
                            state_r            <= ST_LOCK;
                            lockout_r          <= 1'b1;
                            lockout_definite_r <= 1'b1;
                            seq_master_r       <= 1'b0;
                            seq_slave_r        <= 1'b0;
                            slave_wait_r       <= 1'b0;
                        end else begin
                            state_r    <= ST_DEAD;
                            attempt_r  <= attempt_r + 3'h1;
                            shot_3ph_r <= 1'b1;
                            if (tmr_done && !slave_active_r) begin
                                slave_active_r <= 1'b1;
                                sec_time2_r    <= 1'b1;
                                slave_wait_r   <= 1'b0;
                            end
                        end
                    end else if (tmr_done) begin
                        state_r      <= ST_IDLE;
                        seq_master_r <= 1'b0;
                        seq_slave_r  <= 1'b0;
                        slave_wait_r <= 1'b0;
                        sec_time2_r  <= 1'b0;
                    end
                end
                ST_LOCK: begin
                    if (both_closed) begin
                        state_r <= ST_MANUAL;
                    end
                end
                ST_MANUAL: begin
                    if (!both_closed) begin
                        state_r <= ST_LOCK;
                    end else if (tmr_done) begin
                        state_r            <= ST_IDLE;
                        lockout_r          <= 1'b0;
                        lockout_definite_r <= 1'b0;
                        sec_time2_r        <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Shot counters
    // ****************************************
    shot_counter #(
        .W (CNT_W)
    ) u_master_cnt (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clear     (cnt_clear_r),
        .incr      (reclose_master_r),
        .is_3ph    (shot_3ph_r),
        .cnt_1ph_r (m_1ph),
        .cnt_3ph_r (m_3ph)
    );

    shot_counter #(
        .W (CNT_W)
    ) u_slave_cnt (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clear     (cnt_clear_r),
        .incr      (reclose_slave_r),
        .is_3ph    (shot_3ph_r),
        .cnt_1ph_r (s_1ph),
        .cnt_3ph_r (s_3ph)
    );

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_evt[IRQ_RECLOSE]  = reclose_master_r || reclose_slave_r;
    assign irq_evt[IRQ_LOCKOUT]  = lockout_r && !lockout_d_r;
    assign irq_evt[IRQ_SUCCESS]  = (state_r == ST_SECURE) && tmr_done && !trip_evt;
    assign irq_evt[IRQ_TAKEOVER] = slave_active_r && !slave_active_d_r;
    assign irq_clr = (wr_en && paddr == OFS_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_stat_r       <= '0;
            irq_r            <= 1'b0;
            lockout_d_r      <= 1'b0;
            slave_active_d_r <= 1'b0;
        end else begin
            lockout_d_r      <= lockout_r;
            slave_active_d_r <= slave_active_r;
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
            irq_r      <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_en_r);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_r && pwrite;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !(paddr == OFS_CTRL || paddr == OFS_STATUS || paddr == OFS_COUNT
                         || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_EN || paddr == OFS_IRQ_CLR);
            if (setup && !pwrite) begin
                case (paddr)
                    OFS_CTRL:     prdata_r <= {29'h0, enable_r, mode_r};
                    OFS_STATUS:   prdata_r <= {21'h0, attempt_r, 1'b0, slave_active_r, slave_wait_r,
                                               sec_time2_r, lockout_definite_r, lockout_r, seq_slave_r,
                                               seq_master_r};
                    OFS_COUNT:    prdata_r <= {16'h0, s_3ph, s_1ph, m_3ph, m_1ph};
                    OFS_IRQ_STAT: prdata_r <= {28'h0, irq_stat_r};
                    OFS_IRQ_EN:   prdata_r <= {28'h0, irq_en_r};
                    default:      prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_r      <= CTRL_RESET[1:0];
            enable_r    <= CTRL_RESET[CTRL_EN_BIT];
            irq_en_r    <= '0;
            cnt_clear_r <= 1'b0;
        end else begin
            cnt_clear_r <= counter_reset_in;
            if (wr_en && paddr == OFS_CTRL) begin
                mode_r      <= pwdata[CTRL_MODE_LSB +: 2];
                enable_r    <= pwdata[CTRL_EN_BIT];
                cnt_clear_r <= pwdata[CTRL_CLR_BIT] || counter_reset_in;
            end
            if (wr_en && paddr == OFS_IRQ_EN) begin
                irq_en_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_trip_starts: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_IDLE && trip_evt && enable_r |=> seq_master_r && seq_slave_r && slave_wait_r)
        else $error("sequence not started by trip");
    a_single_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_IDLE && trip_evt && enable_r && !three_phase_trip_activation && mode_r != MODE_3P
        |=> !shot_3ph_r)
        else $error("single-phase trip not taken as single-phase");
    a_master_shot: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_DEAD && tmr_done && !slave_active_r |=> reclose_master_r && slave_wait_r)
        else $error("master did not reclose");
    a_attempt_cap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        attempt_r <= 3'(MAX_SHOTS))
        else $error("attempt count above limit");
    a_lock_drops: assert property (@(posedge clk_sys) disable iff (!reset_n)
        lockout_r |-> !seq_master_r && !seq_slave_r && !reclose_master_r && !reclose_slave_r)
        else $error("lockout with sequence active");
    a_lock_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_MANUAL && both_closed && tmr_done |=> !lockout_r && !lockout_definite_r)
        else $error("lockout not released");
    a_later_3ph: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_DEAD && attempt_r > 3'h1 |-> shot_3ph_r)
        else $error("later attempt not three-phase");
    a_slave_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !slave_active_r && !cnt_clear_r ##1 !slave_active_r |-> $stable(s_1ph) && $stable(s_3ph))
        else $error("slave counted without takeover");
    a_takeover: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_SECURE && trip_evt && tmr_done && attempt_r < max_shots && !slave_active_r
        |=> sec_time2_r && slave_active_r && state_r == ST_DEAD)
        else $error("slave takeover failed");
    a_slave_shot: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == ST_DEAD && tmr_done && slave_active_r |=> reclose_slave_r && !reclose_master_r)
        else $error("slave did not reclose after takeover");
    a_3ph_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        first_3ph_r && state_r != ST_IDLE |-> shot_3ph_r)
        else $error("single-phase shot in three-phase sequence");
    a_dep_lock: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mode_r == MODE_DEP && first_3ph_r && state_r == ST_SECURE && trip_evt |=> lockout_r)
        else $error("dependent mode did not lock out");
    a_master_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reclose_master_r && !cnt_clear_r && m_3ph != '1 && m_1ph != '1
        |=> (m_1ph + m_3ph) == $past(m_1ph + m_3ph) + 1'b1)
        else $error("master counters not stepped by one");
endmodule

// *** verilog/reclose_pkg.sv ***
// Constants, types and register map of the dual recloser sequencer.
// Assumes a single 25 MHz system clock and an APB register bus.
package reclose_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int T_RCL_1PH_MS  = 500;
    localparam int T_RCL_3PH1_MS = 800;
    localparam int T_RCL_3PHN_MS = 1000;
    localparam int T_SEC1_MS     = 2000;
    localparam int T_SEC2_MS     = 2000;
    localparam int T_MAN_SEC_MS  = 3000;
    localparam int RCL_1PH_CYC   = T_RCL_1PH_MS * CYC_PER_MS;
    localparam int RCL_3PH1_CYC  = T_RCL_3PH1_MS * CYC_PER_MS;
    localparam int RCL_3PHN_CYC  = T_RCL_3PHN_MS * CYC_PER_MS;
    localparam int SEC1_CYC      = T_SEC1_MS * CYC_PER_MS;
    localparam int SEC2_CYC      = T_SEC2_MS * CYC_PER_MS;
    localparam int MAN_SEC_CYC   = T_MAN_SEC_MS * CYC_PER_MS;
    localparam int MAX_SHOTS     = 4;
    localparam int CNT_W         = 4;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_COUNT    = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_BIT   = 2;
    localparam int CTRL_CLR_BIT  = 3;
    localparam logic [2:0] CTRL_RESET = 3'h4;

    localparam int IRQ_W        = 4;
    localparam int IRQ_RECLOSE  = 0;
    localparam int IRQ_LOCKOUT  = 1;
    localparam int IRQ_SUCCESS  = 2;
    localparam int IRQ_TAKEOVER = 3;

    typedef enum logic [1:0] {
        MODE_1P3P = 2'h0,
        MODE_3P   = 2'h1,
        MODE_DEP  = 2'h2
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEAD,
        ST_SECURE,
        ST_LOCK,
        ST_MANUAL
    } state_t;

endpackage

// *** verilog/interval_timer.sv ***
// Loadable down counter flagging the last cycle of an interval.
// Assumes load values of at least one.
`timescale 1ns/1ns
module interval_timer #(
    parameter int W = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              done
);
    logic [W-1:0] cnt_r;

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= load;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});

    a_timer_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
        done |=> cnt_r == '0 || $past(start))
        else $error("timer did not end after done");
endmodule

// *** verilog/shot_counter.sv ***
// Single-phase and three-phase shot counters of one recloser.
// Assumes incr is a one-cycle pulse.
`timescale 1ns/1ns
module shot_counter #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         clear,
    input  wire logic         incr,
    input  wire logic         is_3ph,
    output logic [W-1:0]      cnt_1ph_r,
    output logic [W-1:0]      cnt_3ph_r
);
    // ****************************************
    // Counters
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n || clear) begin
            cnt_1ph_r <= '0;
            cnt_3ph_r <= '0;
        end else if (incr) begin
            if (is_3ph && cnt_3ph_r != '1) begin
                cnt_3ph_r <= cnt_3ph_r + 1'b1;
            end else if (!is_3ph && cnt_1ph_r != '1) begin
                cnt_1ph_r <= cnt_1ph_r + 1'b1;
            end
        end
    end

    a_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clear |=> cnt_1ph_r == '0 && cnt_3ph_r == '0)
        else $error("counters not cleared");
    a_one_counter: assert property (@(posedge clk_sys) disable iff (!reset_n)
        incr && !clear && is_3ph |=> $stable(cnt_1ph_r))
        else $error("wrong counter stepped");
endmodule

// *** verification/breaker_trip_model.sv ***
// Behavioural model of two breakers and the protection tripping logic.
// Assumes the bench pulses fault and manual_close for one clk_sys cycle.
`timescale 1ns/1ns
module breaker_trip_model (
    input  wire logic clk_sys,
    input  wire logic fault,
    input  wire logic fault_3ph,
    input  wire logic manual_close,
    input  wire logic reclose_master_r,
    input  wire logic reclose_slave_r,
    output logic      external_trip_activation,
    output logic      three_phase_trip_activation,
    output logic      breaker1_closed,
    output logic      breaker2_closed
);
    logic [1:0] hold_r;
    initial begin
        {external_trip_activation, three_phase_trip_activation, hold_r} = 4'h0;
        {breaker1_closed, breaker2_closed} = 2'h3;
    end
    // ****
    // Trip pulse opens both breakers
    // ****
    always @(posedge clk_sys) begin
        if (fault) begin
            hold_r <= 2'h3;
            external_trip_activation <= 1'b1;
            three_phase_trip_activation <= fault_3ph;
            {breaker1_closed, breaker2_closed} <= 2'h0;
        end else if (hold_r != 2'h0) begin
            hold_r <= hold_r - 2'h1;
        end else begin
            {external_trip_activation, three_phase_trip_activation} <= 2'h0;
        end
        if (reclose_master_r || reclose_slave_r || manual_close) begin
            {breaker1_closed, breaker2_closed} <= 2'h3;
        end
    end
endmodule

// *** verification/dual_recloser_sequencer_bench.sv ***
// Self-checking bench of the dual recloser sequencer.
// Assumes shortened reclose, security and manual-close times.
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module dual_recloser_sequencer_bench;
    import reclose_pkg::*;
    localparam int T1P = 20, T3F = 25, T3N = 30, TS = 40, TM = 30;
    logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err_q;
    logic fault = 0, fault_3ph = 0, manual_close = 0, counter_reset_in = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd_q, prdata_r;
    logic pready_r, pslverr_r, external_trip_activation, three_phase_trip_activation, breaker1_closed;
    logic breaker2_closed, seq_master_r, seq_slave_r, slave_wait_r, sec_time2_r, lockout_r, lockout_definite_r;
    logic reclose_master_r, reclose_slave_r, irq_r;
    int errors = 0, samples_checked = 0, cycles = 0, n, k, tt;
    typedef struct {mode_t m; logic t3; logic [3:0] c1; logic [3:0] c3;} row_t;
    row_t rows [5] = '{'{MODE_1P3P, 1'b0, 4'h1, 4'h3}, '{MODE_1P3P, 1'b1, 4'h0, 4'h4},
        '{MODE_DEP, 1'b0, 4'h1, 4'h3}, '{MODE_DEP, 1'b1, 4'h0, 4'h1}, '{MODE_3P, 1'b0, 4'h0, 4'h4}};
    dual_recloser_sequencer #(.RCL_1PH_T(T1P), .RCL_3PH1_T(T3F), .RCL_3PHN_T(T3N), .SEC1_T(TS), .SEC2_T(TS),
        .MAN_SEC_T(TM)) dut_u (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
        .pready_r, .pslverr_r, .external_trip_activation, .three_phase_trip_activation, .breaker1_closed,
        .breaker2_closed, .counter_reset_in, .seq_master_r, .seq_slave_r, .slave_wait_r, .sec_time2_r,
        .lockout_r, .lockout_definite_r, .reclose_master_r, .reclose_slave_r, .irq_r);
    breaker_trip_model part_u (.clk_sys, .fault, .fault_3ph, .manual_close, .reclose_master_r,
        .reclose_slave_r, .external_trip_activation, .three_phase_trip_activation, .breaker1_closed,
        .breaker2_closed);
    always #20 clk_sys = ~clk_sys;
    // ****
    // Tasks
    // ****
    task stop_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready_r !== 1'b1);
        rd_q = prdata_r;
        err_q = pslverr_r;
        {psel, penable} <= 2'h0;
    endtask
    task fault_on(input logic t3);
        @(posedge clk_sys);
        {fault, fault_3ph} <= {1'b1, t3};
        @(posedge clk_sys);
        fault <= 1'b0;
    endtask
    task wait_rcl(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge clk_sys);
            if (reclose_master_r === 1'b1 || reclose_slave_r === 1'b1) break;
        end
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err_q, 1'b1);
        foreach (rows[i]) begin
            apb(1'b1, OFS_CTRL, {28'h0, 1'b0, 1'b1, rows[i].m});
            k = rows[i].c1 + rows[i].c3;
            for (int s = 0; s <= k; s++) begin
                fault_on(rows[i].t3);
                if (s == k) break;
                wait_rcl(80);
                tt = s > 0 ? T3N : (rows[i].t3 || rows[i].m == MODE_3P) ? T3F : T1P;
                `CHK(n >= tt + 2 && n <= tt + 3, 1'b1);
                `CHK({reclose_slave_r, seq_master_r, seq_slave_r, slave_wait_r}, 4'h7);
                repeat (8) @(posedge clk_sys);
            end
            repeat (4) @(posedge clk_sys);
            `CHK({lockout_r, lockout_definite_r, seq_master_r, seq_slave_r}, 4'hc);
            wait_rcl(TS + 20);
            `CHK(n, TS + 21);
            apb(1'b0, OFS_COUNT, 32'h0);
            `CHK(rd_q[15:0], {8'h00, rows[i].c3, rows[i].c1});
            @(posedge clk_sys) manual_close <= 1'b1;
            @(posedge clk_sys) manual_close <= 1'b0;
            for (n = 0; n < 100 && lockout_r !== 1'b0; n++) @(posedge clk_sys);
            `CHK(n >= TM && n <= TM + 5 && lockout_definite_r === 1'b0, 1'b1);
            if (i % 2) apb(1'b1, OFS_CTRL, {28'h0, 1'b1, 1'b1, rows[i].m});
            else begin
                @(posedge clk_sys) counter_reset_in <= 1'b1;
                @(posedge clk_sys) counter_reset_in <= 1'b0;
            end
            repeat (2) @(posedge clk_sys);
            apb(1'b0, OFS_COUNT, 32'h0);
            `CHK(rd_q[15:0], 16'h0);
        end
        apb(1'b1, OFS_CTRL, 32'h4);
        fault_on(1'b0);
        wait_rcl(80);
        repeat (TS - 4) @(posedge clk_sys);
        fault_on(1'b0);
        wait_rcl(80);
        `CHK(n, T3N + 2);
        `CHK({reclose_master_r, reclose_slave_r, sec_time2_r, slave_wait_r}, 4'h6);
        repeat (TS + 5) @(posedge clk_sys);
        apb(1'b0, OFS_COUNT, 32'h0);
        `CHK(rd_q[15:0], 16'h1001);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        `CHK(rd_q[3:0], 4'hf);
        `CHK(irq_r, 1'b0);
        apb(1'b1, OFS_IRQ_EN, 32'h2);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_r, 1'b1);
        apb(1'b1, OFS_IRQ_CLR, 32'hf);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_r, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0);
        fault_on(1'b0);
        repeat (4) @(posedge clk_sys);
        `CHK(seq_master_r, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h4);
        fault_on(1'b0);
        repeat (3) @(posedge clk_sys);
        `CHK({seq_master_r, seq_slave_r}, 2'h3);
        reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        `CHK({seq_master_r, lockout_r, irq_r}, 3'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rd_q[3:0], {1'b0, CTRL_RESET});
        stop_test();
    end
endmodule
